// ==== spip_pkg.sv ====
// Shared constants and types for the shared peripheral request block
package spip_pkg;

   // ==========================================================
   // Control register bit positions (one byte per side)
   localparam int FLAG1_BIT  = 7;  // Primary flag
   localparam int FLAG2_BIT  = 6;  // Secondary flag
   localparam int DIR2_BIT   = 5;  // Secondary line direction, 1 = output
   localparam int EDGE2_BIT  = 4;  // Secondary active edge, 1 = rising
   localparam int EN2_BIT    = 3;  // Secondary enable
   localparam int EDGE1_BIT  = 1;  // Primary active edge, 1 = rising
   localparam int EN1_BIT    = 0;  // Primary enable

   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] SYNC_RST = 2'h0;

   // ==========================================================
   // Per-side control bundle written by the host core
   typedef struct packed {
      logic dir2;    // Secondary line is an output
      logic edge2;   // Secondary active edge
      logic en2;     // Secondary enable
      logic edge1;   // Primary active edge
      logic en1;     // Primary enable
   } spip_cfg_t;

   // Per-side flag status
   typedef struct packed {
      logic flag1;
      logic flag2;
   } spip_flags_t;

endpackage : spip_pkg

// ==== spip_channel.sv ====
// One adapter side: edge detect, sticky flags and open-drain request
`timescale 1ns/1ns
`default_nettype none

module spip_channel
   import spip_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // Control
   input  wire spip_cfg_t   cfg_i,
   input  wire logic        clear_i,
   // Synchronised line levels
   input  wire logic        line1_i,
   input  wire logic        line2_i,
   // Status
   output logic             flag1_o,
   output logic             flag2_o,
   output logic             req_o
);

   // ==========================================================
   // State
   logic prev1;
   logic prev2;
   logic flag1;
   logic flag2;
   logic req;
   logic next_flag1;
   logic next_flag2;
   logic next_req;
   logic hit1;
   logic hit2;

   // Flag next values; a new edge in the clearing cycle wins
   always_comb begin
      hit1 = cfg_i.edge1 ? (line1_i & ~prev1) : (~line1_i & prev1);
      hit2 = cfg_i.edge2 ? (line2_i & ~prev2) : (~line2_i & prev2);
      // Flag sets whatever the enable says
      next_flag1 = hit1 | (flag1 & ~clear_i); // [R2] [R13]
      // Output-mode line cannot raise its flag
      next_flag2 = (hit2 & ~cfg_i.dir2) | (flag2 & ~clear_i); // [R4] [R13]
      // Request only for enabled flags; clear releases it at once
      next_req = (next_flag1 & cfg_i.en1) // [R3] [R6]
               | (next_flag2 & cfg_i.en2 & ~cfg_i.dir2); // [R4] [R5]
   end

   // Register stage
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev1 <= 1'b0;
         prev2 <= 1'b0;
         flag1 <= 1'b0;
         flag2 <= 1'b0;
         req   <= 1'b0;
      end else begin
         prev1 <= line1_i;
         prev2 <= line2_i;
         flag1 <= next_flag1;
         flag2 <= next_flag2;
         req   <= next_req;
      end
   end

   assign flag1_o = flag1;
   assign flag2_o = flag2;
   assign req_o   = req;

   // ==========================================================
   // Checks
   a_flag_ignores_en: assert property (@(posedge sys_clk_i) // [R2]
      disable iff (!rst_n_i) (hit1 && !cfg_i.en1) |=> flag1)
      else $error("primary flag not set while disabled");
   a_req_needs_en: assert property (@(posedge sys_clk_i) // [R3]
      disable iff (!rst_n_i)
      (req && !$past(next_flag2)) |-> $past(next_flag1 && cfg_i.en1))
      else $error("request without enabled primary flag");
   a_out_no_req: assert property (@(posedge sys_clk_i) // [R4]
      disable iff (!rst_n_i)
      ($past(cfg_i.dir2) && !$past(next_flag1 && cfg_i.en1)) |-> !req)
      else $error("output-mode secondary raised request");
   a_sec_req: assert property (@(posedge sys_clk_i) // [R5]
      disable iff (!rst_n_i)
      (next_flag2 && cfg_i.en2 && !cfg_i.dir2) |=> req)
      else $error("enabled secondary flag gave no request");
   a_flag_sticky: assert property (@(posedge sys_clk_i) // [R13]
      disable iff (!rst_n_i)
      (flag1 && !clear_i) |=> flag1)
      else $error("primary flag lost without clear");

endmodule // spip_channel

`default_nettype wire

// ==== spip_irq_poll.sv ====
// Shared request aggregation for several parallel adapters
`timescale 1ns/1ns
`default_nettype none

// How it works
// [R1] Every side's request joins one open-drain, active-low shared line.
// [R2] Primary flag sets on each active edge even while disabled.
// [R3] Primary request drives low only when flag and enable are both 1.
// [R4] Secondary line as output gives no secondary request.
// [R5] Secondary input requests only when its enable bit is set.
// [R6] Clearing a flag releases that side's drive immediately; here the shared line is released two edges after the clear.
// [R7] Processor fetches its vector from the two maskable-request locations.
// [R8] Service code sets priority by its fixed polling order.
// [R9] Return from service unmasks, so a still-pending request is taken.
// [R10] Service code tests the disk read/write flag first.
// [R11] Display source is tested by flag only, never by enable.
// [R12] Line low with no flag set is treated as noise.
// [R13] Flags stay set until cleared; dropping enable never clears them.

// ==========================================================
// Integration notes
// Every side of every adapter has its own flag pair and its own
// request, and the block ORs the enabled requests into one pull-down
// on the shared active-low line. The polling core reads the flag
// status, picks the first pending side in its own order and pulses
// that side's clear. The block never ranks the sides: priority is
// purely the core's business, which keeps this logic flat.
// Latency from a pin edge to the line is four edges (two for the
// synchroniser, one for the flag, one for the output flop); a user
// who needs faster service must accept metastability risk instead.
// A clear releases the side two edges later unless a fresh edge
// lands in the same cycle, in which case the flag survives on
// purpose, so no event is lost between read and clear.

module spip_irq_poll
   import spip_pkg::*;
#(
   parameter int NUM_ADAPT = 4
)(
   // Clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_n_i,
   // Per-side configuration, index 2*n = side a, 2*n+1 = side b
   input  wire spip_cfg_t [2*NUM_ADAPT-1:0] cfg_i,
   // Clearing access per side, one-cycle pulse
   input  wire logic [2*NUM_ADAPT-1:0] clear_i,
   // Control line pins from peripherals (asynchronous)
   input  wire logic [2*NUM_ADAPT-1:0] primary_line_i,
   input  wire logic [2*NUM_ADAPT-1:0] secondary_line_i,
   // Shared request pin, open drain
   input  wire logic                   irq_line_i,
   output logic                        irq_line_o,
   output logic                        irq_line_oe_o,
   // Flag status for the polling core
   output spip_flags_t [2*NUM_ADAPT-1:0] flags_o,
   output logic [2*NUM_ADAPT-1:0]      side_req_o,
   // Synchronised shared line level, low = request pending
   output logic                        irq_sense_n_o
);

   localparam int NS = 2 * NUM_ADAPT;

   // ==========================================================
   // Reset release through two flip-flops
   logic [1:0] rst_sync;
   logic       rst_n;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync <= SYNC_RST;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ==========================================================
   // Pin synchronisers; first stage feeds only the second
   logic [NS-1:0] p1_s0, p1_s1, p2_s0, p2_s1;
   logic [1:0]    irq_s;
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         p1_s0 <= '0;
         p1_s1 <= '0;
         p2_s0 <= '0;
         p2_s1 <= '0;
         irq_s <= 2'h3;
      end else begin
         p1_s0 <= primary_line_i;
         p1_s1 <= p1_s0;
         p2_s0 <= secondary_line_i;
         p2_s1 <= p2_s0;
         irq_s <= {irq_s[0], irq_line_i};
      end
   end

   // ==========================================================
   // One channel per adapter side
   logic [NS-1:0] f1, f2, req;
   for (genvar i = 0; i < NS; i++) begin : g_side
      spip_channel u_ch (
         .sys_clk_i (sys_clk_i),
         .rst_n_i   (rst_n),
         .cfg_i     (cfg_i[i]),
         .clear_i   (clear_i[i]),
         .line1_i   (p1_s1[i]),
         .line2_i   (p2_s1[i]),
         .flag1_o   (f1[i]),
         .flag2_o   (f2[i]),
         .req_o     (req[i])
      );
   end

   // ==========================================================
   // Wired-OR of all sides onto the shared active-low line
   logic              drive;
   logic              next_drive;
   spip_flags_t [NS-1:0] flags;
   always_comb begin
      next_drive = |req; // [R1] [R6]
      for (int k = 0; k < NS; k++) begin
         flags[k].flag1 = f1[k];
         flags[k].flag2 = f2[k];
      end
   end

   // Output registers; pin only ever pulled low, never driven high
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         drive         <= 1'b0;
         flags_o       <= '0;
         side_req_o    <= '0;
         irq_sense_n_o <= 1'b1;
      end else begin
         drive         <= next_drive; // [R1]
         flags_o       <= flags;
         side_req_o    <= req;
         irq_sense_n_o <= irq_s[1];
      end
   end

   assign irq_line_o    = 1'b0;
   assign irq_line_oe_o = drive;

   // ==========================================================
   // Checks
   a_wired_drive: assert property (@(posedge sys_clk_i) // [R1]
      disable iff (!rst_n) (|req) |=> irq_line_oe_o)
      else $error("pending side did not pull shared line");
   a_clear_release: assert property (@(posedge sys_clk_i) // [R6]
      disable iff (!rst_n)
      (!(|req)) |=> !irq_line_oe_o)
      else $error("shared line held with nothing pending");
   a_low_only: assert property (@(posedge sys_clk_i) // [R1]
      disable iff (!rst_n) irq_line_oe_o |-> (irq_line_o == 1'b0))
      else $error("shared line driven high");

   // ==========================================================
   // Output mirrors; the polling core must see exactly what the
   // channels held one edge earlier, never a half-settled value
   a_flags_mirror: assert property (@(posedge sys_clk_i) // [R2]
      disable iff (!rst_n) flags_o == $past(flags))
      else $error("flag status copy out of step");
   a_side_mirror: assert property (@(posedge sys_clk_i) // [R3]
      disable iff (!rst_n) side_req_o == $past(req))
      else $error("side request copy out of step");
   a_oe_matches: assert property (@(posedge sys_clk_i) // [R1]
      disable iff (!rst_n) irq_line_oe_o == (|side_req_o))
      else $error("line drive differs from side requests");

   // Sense path is three edges deep; the first edges after reset
   // still carry the reset value, so they are skipped
   a_sense_follow: assert property (@(posedge sys_clk_i) // [R1]
      disable iff (!rst_n)
      $past(rst_n, 3) |-> (irq_sense_n_o == $past(irq_line_i, 3)))
      else $error("shared line sense lags or leads");

   // ==========================================================
   // Per-side checks, one copy for every adapter side
   for (genvar j = 0; j < NS; j++) begin : g_chk
      // A side with no enabled source must leave the line alone
      a_quiet_side: assert property (@(posedge sys_clk_i) // [R3]
         disable iff (!rst_n)
         (!cfg_i[j].en1 && (!cfg_i[j].en2 || cfg_i[j].dir2))
         |=> !req[j])
         else $error("disabled side raised its request");
      // Output-mode secondary line can never raise its flag
      a_dir_blocks: assert property (@(posedge sys_clk_i) // [R4]
         disable iff (!rst_n)
         (cfg_i[j].dir2 && !f2[j]) |=> !f2[j])
         else $error("output-mode secondary flag set");
      // Secondary flag is as sticky as the primary one
      a_sec_sticky: assert property (@(posedge sys_clk_i) // [R13]
         disable iff (!rst_n)
         (f2[j] && !clear_i[j]) |=> f2[j])
         else $error("secondary flag lost without clear");
      // A clear with quiet pins drops flags and request together;
      // a pin that moved may carry a new edge, which must win
      a_clear_frees: assert property (@(posedge sys_clk_i) // [R6]
         disable iff (!rst_n)
         (clear_i[j] && $stable(p1_s1[j]) && $stable(p2_s1[j]))
         |=> (!req[j] && !f1[j] && !f2[j]))
         else $error("clear did not release the side");
   end

endmodule // spip_irq_poll

`default_nettype wire

// ==== spip_core_model.sv ====
// Polling core model that services the shared request line
`timescale 1ns/1ns
`default_nettype none

module spip_core_model
   import spip_pkg::*;
#(
   parameter int NS   = 8,
   parameter int DISP = 6
)(
   // Clock and control
   input  wire logic                sys_clk_i,
   input  wire logic                go_i,
   // Status from the block
   input  wire logic                irq_sense_n_i,
   input  wire spip_flags_t [NS-1:0] flags_i,
   input  wire spip_cfg_t [NS-1:0]   cfg_i,
   // Clearing accesses
   output logic [NS-1:0]            clear_o
);
   int pick;

   // ========================================================
   // Service loop; an unserviced line is only noise, so it just returns
   initial clear_o = '0;
   always begin
      @(posedge sys_clk_i);
      if (go_i && irq_sense_n_i === 1'b0) begin
         pick = -1;
         // Fixed order, side 0 (disk) first, sets the priority
         for (int s = 0; s < NS; s++) begin
            if (pick < 0 && ((flags_i[s].flag1 && (cfg_i[s].en1 || s == DISP))
                || (flags_i[s].flag2 && cfg_i[s].en2 && !cfg_i[s].dir2)))
               pick = s;
         end
         if (pick >= 0) begin
            clear_o[pick] <= 1'b1;
            @(posedge sys_clk_i);
            clear_o <= '0;
         end
         // Return unmasks; a pending line is taken again next
         repeat (4) @(posedge sys_clk_i);
      end
   end
endmodule // spip_core_model

`default_nettype wire

// ==== test_spip_irq_poll.sv ====
// Self-checking testbench for the shared request block
`timescale 1ns/1ns
`default_nettype none

module test_spip_irq_poll
   import spip_pkg::*;
;
   localparam int NS = 8;
   logic                 sys_clk_i = 1'b0;
   logic                 rst_n_i   = 1'b0;
   logic                 go        = 1'b0;
   spip_cfg_t [NS-1:0]   cfg       = '0;
   logic [NS-1:0]        pri       = '0;
   logic [NS-1:0]        sec       = '0;
   logic [NS-1:0]        clr;
   logic                 irq_line_i;
   logic                 irq_line_o;
   logic                 irq_line_oe_o;
   logic                 irq_sense_n_o;
   spip_flags_t [NS-1:0] flags_o;
   logic [NS-1:0]        side_req_o;
   int                   errors    = 0;
   int                   cmp_count = 0;
   int                   cyc       = 0;

   // ========================================================
   // Clock, wired line with pull-up, and the hang guard
   initial forever #20 sys_clk_i = ~sys_clk_i;
   assign irq_line_i = irq_line_oe_o ? irq_line_o : 1'b1;
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errors++;
         test_done();
      end
   end

   spip_irq_poll #(.NUM_ADAPT(4)) dut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
      .clear_i(clr), .primary_line_i(pri), .secondary_line_i(sec),
      .irq_line_i(irq_line_i), .irq_line_o(irq_line_o),
      .irq_line_oe_o(irq_line_oe_o), .flags_o(flags_o),
      .side_req_o(side_req_o), .irq_sense_n_o(irq_sense_n_o));

   spip_core_model #(.NS(NS), .DISP(6)) core (
      .sys_clk_i(sys_clk_i), .go_i(go), .irq_sense_n_i(irq_sense_n_o),
      .flags_i(flags_o), .cfg_i(cfg), .clear_o(clr));

   // ========================================================
   // Shared helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic do_reset();
      rst_n_i <= 1'b0;
      cfg     <= '0;
      cyc_n(8);
      rst_n_i <= 1'b1;
      cyc_n(4);
   endtask

   // Pulse a pin high; flag shows about four edges after the rise
   task automatic hit(input int s, input bit two);
      if (two) sec[s] <= 1'b1;
      else pri[s] <= 1'b1;
      cyc_n(3);
      sec <= '0;
      pri <= '0;
      cyc_n(5);
   endtask

   // ========================================================
   // Scenarios
   task automatic t_primary();
      cfg[1].edge1 <= 1'b1;
      hit(1, 1'b0);
      chk(flags_o[1].flag1, 1'b1);
      chk(irq_line_oe_o, 1'b0);
      cfg[1].en1 <= 1'b1;
      cyc_n(3);
      chk(side_req_o, 16'h0002);
      chk(irq_line_o, 1'b0);
      cyc_n(3);
      chk(irq_sense_n_o, 1'b0);
      cfg[1].en1 <= 1'b0;
      cyc_n(3);
      chk(irq_line_oe_o, 1'b0);
      chk(flags_o[1].flag1, 1'b1);
      cfg[1].en1 <= 1'b1;
      go <= 1'b1;
      cyc_n(14);
      chk(flags_o, 16'h0000);
      chk(irq_line_oe_o, 1'b0);
      go <= 1'b0;
   endtask

   task automatic t_secondary();
      cfg[3] <= 5'h1c;
      hit(3, 1'b1);
      chk(side_req_o[3], 1'b0);
      chk(irq_line_oe_o, 1'b0);
      cfg[3] <= 5'h08;
      hit(3, 1'b1);
      chk(flags_o[3].flag2, 1'b1);
      chk(side_req_o[3], 1'b0);
      cfg[3].en2 <= 1'b1;
      cyc_n(3);
      chk(side_req_o[3], 1'b1);
   endtask

   task automatic t_prio();
      cfg[0] <= 5'h03;
      cfg[2] <= 5'h03;
      pri    <= 8'h05;
      cyc_n(3);
      pri <= '0;
      cyc_n(5);
      chk(side_req_o, 16'h0005);
      go <= 1'b1;
      for (int i = 0; i < 40 && flags_o[0].flag1 !== 1'b0; i++)
         @(posedge sys_clk_i);
      chk(flags_o[2].flag1, 1'b1);
      cyc_n(14);
      chk(flags_o[2].flag1, 1'b0);
      chk(irq_line_oe_o, 1'b0);
      go <= 1'b0;
   endtask

   // ========================================================
   // Closing report, the single place the run ends
   task automatic test_done();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      do_reset();
      chk(irq_sense_n_o, 1'b1);
      chk(flags_o, 16'h0000);
      t_primary();
      do_reset();
      t_secondary();
      do_reset();
      t_prio();
      test_done();
   end
endmodule // test_spip_irq_poll

`default_nettype wire
